// File: bcc_bus_model.sv
// Bus sensing and ramp partner of the brake chopper control
`timescale 1ns/1ps
`default_nettype none
module bcc_bus_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] level_i,
  input  wire logic        hold_i,
  output logic      [15:0] bus_voltage_o,
  output logic      [15:0] setpoint_o
);
  initial begin
    bus_voltage_o = 16'h0000;
    setpoint_o    = 16'h0000;
  end
  // Sensed level lags the request by one clock, as a real sampler would
  always @(posedge clk_i) begin
    bus_voltage_o <= level_i;
    if (!hold_i) begin
      setpoint_o <= setpoint_o + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// File: bcc_monitor.sv
// Port checker for the brake chopper control block
`timescale 1ns/1ps
`default_nettype none
module bcc_monitor #(
  parameter int TICK_CYCLES = 20
) (
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic [15:0] bus_voltage_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        brake_switch_o,
  input wire logic        ramp_hold_o,
  input wire logic        overload_trip_o,
  input wire logic        irq_o
);
  // ************************************************************
  // Shadow of settings and tick
  // ************************************************************
  logic       en_q;
  logic       trip_q;
  logic [2:0] mask_q;
  int         cnt;
  logic       tick;
  assign tick = (cnt == TICK_CYCLES - 1);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      en_q   <= 1'b1;
      trip_q <= 1'b0;
      mask_q <= 3'h0;
      cnt    <= 0;
    end else begin
      cnt <= tick ? 0 : cnt + 1;
      if (reg_wr_i && reg_addr_i == bcc_pkg::ADDR_CTRL) begin
        en_q   <= reg_wdata_i[0];
        trip_q <= reg_wdata_i[1];
      end
      if (reg_wr_i && reg_addr_i == bcc_pkg::ADDR_INT_MASK) begin
        mask_q <= reg_wdata_i[2:0];
      end
    end
  end
  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // A write on the tick edge may move enable, so those edges are skipped
  sequence s_live;
    tick && en_q && !reg_wr_i;
  endsequence
  sequence s_high;
    s_live ##0 (bus_voltage_i > bcc_pkg::BUS_ON_LEVEL);
  endsequence
  sequence s_low;
    s_live ##0 (bus_voltage_i < bcc_pkg::BUS_OFF_LEVEL);
  endsequence
  a_brake_on: assert property (s_high |=> brake_switch_o)
    else $error("brake switch not on after high sample");
  a_brake_off: assert property (s_low |=> !brake_switch_o)
    else $error("brake switch not off after low sample");
  a_brake_band: assert property (s_live ##0 !(bus_voltage_i > bcc_pkg::BUS_ON_LEVEL)
    ##0 !(bus_voltage_i < bcc_pkg::BUS_OFF_LEVEL) |=> $stable(brake_switch_o))
    else $error("brake switch moved inside band");
  a_hold_follow: assert property (s_live |=> ramp_hold_o == ($past(bus_voltage_i) > bcc_pkg::BUS_ON_LEVEL))
    else $error("hold does not follow sample");
  // The switch drops one clock after enable clears, so the first disabled cycle is skipped
  a_disable_off: assert property (!en_q && !$past(en_q) |-> !brake_switch_o && !ramp_hold_o)
    else $error("switch or hold active while disabled");
  a_trip_gated: assert property (!trip_q && !$past(trip_q) |-> !overload_trip_o)
    else $error("trip raised with option off");
  a_status_read: assert property (reg_rd_i && reg_addr_i == bcc_pkg::ADDR_STATUS
    |=> reg_rdata_o[2:0] == {$past(overload_trip_o), $past(ramp_hold_o), $past(brake_switch_o)})
    else $error("status read does not match outputs");
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data outside read cycle");
  a_irq_masked: assert property (mask_q == 3'h0 |-> !irq_o)
    else $error("interrupt with all masked");
endmodule
`default_nettype wire

// File: bcc_pkg.sv
// Constants shared by the brake chopper control block
package bcc_pkg;
  // ************************************************************
  // Register map (word offsets on the plain register port)
  // ************************************************************
  localparam logic [3:0] ADDR_CTRL       = 4'h0;
  localparam logic [3:0] ADDR_OHMS       = 4'h1;
  localparam logic [3:0] ADDR_POWER      = 4'h2;
  localparam logic [3:0] ADDR_FACTOR     = 4'h3;
  localparam logic [3:0] ADDR_STATUS     = 4'h4;
  localparam logic [3:0] ADDR_BUS_V      = 4'h5;
  localparam logic [3:0] ADDR_LOAD       = 4'h6;
  localparam logic [3:0] ADDR_SW_ENERGY  = 4'h7;
  localparam logic [3:0] ADDR_INT_STAT   = 4'h8;
  localparam logic [3:0] ADDR_INT_MASK   = 4'h9;
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int CTRL_TRIP_EN_BIT = 1;
  localparam int ST_BRAKING_BIT   = 0;
  localparam int ST_HOLD_BIT      = 1;
  localparam int ST_TRIP_BIT      = 2;
  localparam int EV_WIDTH         = 3;
  // ************************************************************
  // Reset values and accepted ranges
  // ************************************************************
  localparam logic [1:0]  CTRL_RESET   = 2'h1;
  localparam logic [9:0]  OHMS_RESET   = 10'h064;
  localparam logic [9:0]  OHMS_MIN     = 10'h001;
  localparam logic [9:0]  OHMS_MAX     = 10'h3E8;
  localparam logic [12:0] POWER_RESET  = 13'h0001;
  localparam logic [12:0] POWER_MIN    = 13'h0001;
  localparam logic [12:0] POWER_MAX    = 13'h13EC;
  localparam logic [5:0]  FACTOR_RESET = 6'h19;
  localparam logic [5:0]  FACTOR_MIN   = 6'h01;
  localparam logic [5:0]  FACTOR_MAX   = 6'h28;
  // Bus voltage levels in tenths of a volt
  localparam logic [15:0] BUS_ON_LEVEL  = 16'h2198;
  localparam logic [15:0] BUS_OFF_LEVEL = 16'h2134;
  // Watts per 0.1 kW power step, ms per overload second, tenths squared
  localparam logic [6:0]  WATT_PER_STEP = 7'h64;
  localparam logic [9:0]  MS_PER_SEC    = 10'h3E8;
  localparam logic [6:0]  TENTHS_SQ     = 7'h64;
  // Switch on-state drop in tenths of a volt
  localparam logic [7:0]  SWITCH_DROP   = 8'h14;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_HZ     = 25000000;
  localparam int TICK_US    = 1000;
  localparam int TICK_COUNT = CLK_HZ / 1000000 * TICK_US;
endpackage

// File: bcc_thermal.sv
// Dump resistor energy and thermal loading estimator
`timescale 1ns/1ps
`default_nettype none
module bcc_thermal (
  input  wire logic   clk_i,
  input  wire logic   rst_b_i,
  bcc_thermal_if.est  th
);
  logic [39:0] load;
  logic [39:0] next_load;
  logic [31:0] sw_energy;
  logic [31:0] next_sw_energy;
  logic [31:0] v_sq;
  logic [16:0] r_x100;
  logic [31:0] p_res;
  logic [19:0] p_cont;
  logic [39:0] capacity;
  logic [40:0] sum;
  logic [25:0] sw_loss;

  // ************************************************************
  // Power terms
  // ************************************************************
  // Divider is combinational; a 1 ms tick leaves ample slack for it
  always_comb begin
    v_sq     = 32'(th.volts) * 32'(th.volts);
    r_x100   = 17'(th.ohms) * 17'(bcc_pkg::TENTHS_SQ);
    p_res    = v_sq / 32'(r_x100);
    p_cont   = 20'(th.power) * 20'(bcc_pkg::WATT_PER_STEP);
    capacity = 40'(th.factor - 6'h01) * 40'(p_cont) * 40'(bcc_pkg::MS_PER_SEC);
    sw_loss  = 26'(32'(th.volts) * 32'(bcc_pkg::SWITCH_DROP) / 32'(r_x100));
  end

  // ************************************************************
  // Energy bucket in watt-milliseconds
  // ************************************************************
  // Resistor heats by its power while switching, cools by its rating
  always_comb begin
    next_load      = load;
    next_sw_energy = sw_energy;
    sum            = 41'(load) + (th.switch_on ? 41'(p_res) : 41'h0);
    if (th.tick) begin
      next_load = (sum > 41'(p_cont)) ? 40'(sum - 41'(p_cont)) : 40'h0;
      if (th.switch_on) begin
        next_sw_energy = sw_energy + 32'(sw_loss);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      load      <= 40'h0;
      sw_energy <= 32'h0;
    end else begin
      load      <= next_load;
      sw_energy <= next_sw_energy;
    end
  end

  assign th.load      = load;
  assign th.sw_energy = sw_energy;
  assign th.overload  = load > capacity;
endmodule
`default_nettype wire

// File: bcc_thermal_if.sv
// Carrier between the brake controller and its thermal estimator
`timescale 1ns/1ps
`default_nettype none
interface bcc_thermal_if;
  logic        tick;
  logic [15:0] volts;
  logic        switch_on;
  logic [9:0]  ohms;
  logic [12:0] power;
  logic [5:0]  factor;
  logic [39:0] load;
  logic [31:0] sw_energy;
  logic        overload;
  modport ctl (output tick, volts, switch_on, ohms, power, factor, input load, sw_energy, overload);
  modport est (input tick, volts, switch_on, ohms, power, factor, output load, sw_energy, overload);
endinterface
`default_nettype wire

// File: bcc_top.sv
// Brake chopper control: bus sampling, brake switch, hold, thermal trip, registers
// Functional notes
// - Braking works only while enable is set; otherwise switch untouched by logic. Code forces the switch off while enable is clear.
// - While enabled, sample bus voltage each millisecond tick and update switch.
// - Read-only status bit shows brake switch conducting.
// - Hold asserted while sampled voltage exceeds threshold; ramp freezes meanwhile. Code asserts hold only while enable is set.
// - Monitoring and switching run regardless of motor output stage enable.
// - Accumulate resistor energy and switch dissipation continuously.
// - Derive resistor thermal loading from energy and configured ratings.
// - With trip option enabled, raise overload trip when loading exceeds capability.
// - Resistor value in ohms held, accepted from 1 to 1000.
// - Continuous power rating held, 0.1 to 510.0 kW in 0.1 kW steps.
// - Short-term overload factor held, integer 1 to 40, for one second.
// - Bus voltage exposed read-only in tenths of a volt.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module bcc_top #(
  parameter int TICK_CYCLES = bcc_pkg::TICK_COUNT
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [15:0] bus_voltage_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  output logic             brake_switch_o,
  output logic             ramp_hold_o,
  output logic             overload_trip_o,
  output logic             irq_o
);
  bcc_thermal_if th ();

  logic [1:0]  ctrl;
  logic [1:0]  next_ctrl;
  logic [9:0]  ohms;
  logic [9:0]  next_ohms;
  logic [12:0] power;
  logic [12:0] next_power;
  logic [5:0]  factor;
  logic [5:0]  next_factor;
  logic [15:0] tick_cnt;
  logic [15:0] next_tick_cnt;
  logic        tick;
  logic [15:0] bus_voltage_reading;
  logic [15:0] next_bus_voltage_reading;
  logic        braking;
  logic        next_braking;
  logic        hold;
  logic        next_hold;
  logic        trip;
  logic        next_trip;
  logic [2:0]  int_stat;
  logic [2:0]  next_int_stat;
  logic [2:0]  int_mask;
  logic [2:0]  next_int_mask;
  logic [2:0]  events;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        enable;

  // Clamps a written value into its accepted range
  function automatic logic [15:0] clamp(input logic [31:0] v, input logic [15:0] lo, input logic [15:0] hi);
    if (v < 32'(lo)) begin
      clamp = lo;
    end else if (v > 32'(hi)) begin
      clamp = hi;
    end else begin
      clamp = v[15:0];
    end
  endfunction

  function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] off, input logic wr);
    wr_hit = wr && (a == off);
  endfunction

  assign enable = ctrl[bcc_pkg::CTRL_ENABLE_BIT];

  // ************************************************************
  // Millisecond tick
  // ************************************************************
  // Tick runs whether the motor output stage is on or not
  always_comb begin
    tick          = (tick_cnt == 16'(TICK_CYCLES - 1));
    next_tick_cnt = tick ? 16'h0 : tick_cnt + 16'h1;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_cnt <= 16'h0;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  // ************************************************************
  // Sampling, brake switch and hold
  // ************************************************************
  // Hysteresis keeps the chopper from chattering on ripple near the level
  always_comb begin
    next_bus_voltage_reading = bus_voltage_reading;
    next_braking             = braking;
    next_hold                = hold;
    next_trip                = ctrl[bcc_pkg::CTRL_TRIP_EN_BIT] && th.overload;
    if (tick) begin
      next_bus_voltage_reading = bus_voltage_i;
    end
    if (!enable) begin
      next_braking = 1'b0;
      next_hold    = 1'b0;
    end else if (tick) begin
      if (bus_voltage_i > bcc_pkg::BUS_ON_LEVEL) begin
        next_braking = 1'b1;
      end else if (bus_voltage_i < bcc_pkg::BUS_OFF_LEVEL) begin
        next_braking = 1'b0;
      end
      next_hold = bus_voltage_i > bcc_pkg::BUS_ON_LEVEL;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_voltage_reading <= 16'h0;
      braking             <= 1'b0;
      hold                <= 1'b0;
      trip                <= 1'b0;
    end else begin
      bus_voltage_reading <= next_bus_voltage_reading;
      braking             <= next_braking;
      hold                <= next_hold;
      trip                <= next_trip;
    end
  end

  assign brake_switch_o  = braking;
  assign ramp_hold_o     = hold;
  assign overload_trip_o = trip;

  // ************************************************************
  // Thermal estimator
  // ************************************************************
  assign th.tick      = tick;
  assign th.volts     = bus_voltage_i;
  assign th.switch_on = braking;
  assign th.ohms      = ohms;
  assign th.power     = power;
  assign th.factor    = factor;

  bcc_thermal u_thermal (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .th      (th)
  );

  // ************************************************************
  // Configuration registers
  // ************************************************************
  // Out-of-range writes are clamped so the divider never sees zero ohms
  always_comb begin
    next_ctrl   = ctrl;
    next_ohms   = ohms;
    next_power  = power;
    next_factor = factor;
    next_int_mask = int_mask;
    if (wr_hit(reg_addr_i, bcc_pkg::ADDR_CTRL, reg_wr_i)) begin
      next_ctrl = reg_wdata_i[1:0];
    end
    if (wr_hit(reg_addr_i, bcc_pkg::ADDR_OHMS, reg_wr_i)) begin
      next_ohms = 10'(clamp(reg_wdata_i, 16'(bcc_pkg::OHMS_MIN), 16'(bcc_pkg::OHMS_MAX)));
    end
    if (wr_hit(reg_addr_i, bcc_pkg::ADDR_POWER, reg_wr_i)) begin
      next_power = 13'(clamp(reg_wdata_i, 16'(bcc_pkg::POWER_MIN), 16'(bcc_pkg::POWER_MAX)));
    end
    if (wr_hit(reg_addr_i, bcc_pkg::ADDR_FACTOR, reg_wr_i)) begin
      next_factor = 6'(clamp(reg_wdata_i, 16'(bcc_pkg::FACTOR_MIN), 16'(bcc_pkg::FACTOR_MAX)));
    end
    if (wr_hit(reg_addr_i, bcc_pkg::ADDR_INT_MASK, reg_wr_i)) begin
      next_int_mask = reg_wdata_i[2:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl     <= bcc_pkg::CTRL_RESET;
      ohms     <= bcc_pkg::OHMS_RESET;
      power    <= bcc_pkg::POWER_RESET;
      factor   <= bcc_pkg::FACTOR_RESET;
      int_mask <= 3'h0;
    end else begin
      ctrl     <= next_ctrl;
      ohms     <= next_ohms;
      power    <= next_power;
      factor   <= next_factor;
      int_mask <= next_int_mask;
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  // Rising edges of switch, hold and trip; a new event beats a clear
  assign events = {next_trip & ~trip, next_hold & ~hold, next_braking & ~braking};

  always_comb begin
    next_int_stat = int_stat;
    if (wr_hit(reg_addr_i, bcc_pkg::ADDR_INT_STAT, reg_wr_i)) begin
      next_int_stat = int_stat & ~reg_wdata_i[2:0];
    end
    next_int_stat = next_int_stat | events;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_stat <= 3'h0;
    end else begin
      int_stat <= next_int_stat;
    end
  end

  assign irq_o = |(int_stat & int_mask);

  // ************************************************************
  // Read data
  // ************************************************************
  always_comb begin
    next_rdata = 32'h0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        bcc_pkg::ADDR_CTRL:      next_rdata = 32'(ctrl);
        bcc_pkg::ADDR_OHMS:      next_rdata = 32'(ohms);
        bcc_pkg::ADDR_POWER:     next_rdata = 32'(power);
        bcc_pkg::ADDR_FACTOR:    next_rdata = 32'(factor);
        bcc_pkg::ADDR_STATUS:    next_rdata = 32'({trip, hold, braking});
        bcc_pkg::ADDR_BUS_V:     next_rdata = 32'(bus_voltage_reading);
        bcc_pkg::ADDR_LOAD:      next_rdata = th.load[39:8];
        bcc_pkg::ADDR_SW_ENERGY: next_rdata = th.sw_energy;
        bcc_pkg::ADDR_INT_STAT:  next_rdata = 32'(int_stat);
        bcc_pkg::ADDR_INT_MASK:  next_rdata = 32'(int_mask);
        default:                 next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata <= 32'h0;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign reg_rdata_o = rdata;
endmodule
`default_nettype wire

// File: bcc_top_test.sv
// Self-checking bench of the brake chopper control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin failures++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, gt); end end
module bcc_top_test;
  localparam int TICK = 20;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
  logic brake, hold, trip, irq;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [15:0] level = 16'h2000, bus_v, sp, sp1;
  int          failures = 0, checked = 0;
  bcc_bus_model model (.clk_i(clk), .level_i(level), .hold_i(hold), .bus_voltage_o(bus_v), .setpoint_o(sp));
  bcc_top #(.TICK_CYCLES(TICK)) uut (.clk_i(clk), .rst_b_i(rst_b), .bus_voltage_i(bus_v), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .brake_switch_o(brake),
    .ramp_hold_o(hold), .overload_trip_o(trip), .irq_o(irq));
  initial begin
    forever #20 clk = ~clk;
  end
  // ************************************************************
  // Bus tasks
  // ************************************************************
  task wrt(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task rdc(input logic [3:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(nm, e, rdata)
  endtask
  // Read whose value depends on tick phase; the caller judges it
  task rdv(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // Sampler lag plus one full tick period
  task ticks;
    repeat (TICK + 3) @(posedge clk);
    #1;
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task t_defaults;
    rdc(bcc_pkg::ADDR_CTRL, 32'h1, "ctrl");
    rdc(bcc_pkg::ADDR_OHMS, 32'h64, "ohms");
    rdc(bcc_pkg::ADDR_POWER, 32'h1, "power");
    rdc(bcc_pkg::ADDR_FACTOR, 32'h19, "factor");
    rdc(bcc_pkg::ADDR_INT_MASK, 32'h0, "mask");
    rdc(4'hF, 32'h0, "unmapped");
  endtask
  task t_clamp;
    wrt(bcc_pkg::ADDR_OHMS, 32'h0); rdc(bcc_pkg::ADDR_OHMS, 32'h1, "ohms lo");
    wrt(bcc_pkg::ADDR_OHMS, 32'h7D0); rdc(bcc_pkg::ADDR_OHMS, 32'h3E8, "ohms hi");
    wrt(bcc_pkg::ADDR_POWER, 32'h2000); rdc(bcc_pkg::ADDR_POWER, 32'h13EC, "power hi");
    wrt(bcc_pkg::ADDR_FACTOR, 32'h32); rdc(bcc_pkg::ADDR_FACTOR, 32'h28, "factor hi");
    wrt(bcc_pkg::ADDR_FACTOR, 32'h0); rdc(bcc_pkg::ADDR_FACTOR, 32'h1, "factor lo");
    wrt(bcc_pkg::ADDR_BUS_V, 32'h5); rdc(bcc_pkg::ADDR_BUS_V, 32'h2000, "bus ro");
    wrt(bcc_pkg::ADDR_OHMS, 32'h64);
  endtask
  task t_brake;
    level <= 16'h2200; ticks;
    `CHK("brake", 1'b1, brake)
    `CHK("hold", 1'b1, hold)
    sp1 = sp; repeat (3) @(posedge clk); #1;
    `CHK("setpoint", sp1, sp)
    rdc(bcc_pkg::ADDR_STATUS, 32'h3, "status");
    rdc(bcc_pkg::ADDR_BUS_V, 32'h2200, "bus");
    level <= 16'h2198; ticks;
    `CHK("brake at on level", 1'b1, brake)
    `CHK("hold at on level", 1'b0, hold)
    level <= 16'h2134; ticks;
    `CHK("brake at off level", 1'b1, brake)
    level <= 16'h2133; ticks;
    `CHK("brake below", 1'b0, brake)
  endtask
  task t_irq;
    rdc(bcc_pkg::ADDR_INT_STAT, 32'h3, "events");
    `CHK("irq masked", 1'b0, irq)
    wrt(bcc_pkg::ADDR_INT_MASK, 32'h1);
    `CHK("irq", 1'b1, irq)
    wrt(bcc_pkg::ADDR_INT_STAT, 32'h7);
    `CHK("irq cleared", 1'b0, irq)
    rdc(bcc_pkg::ADDR_INT_STAT, 32'h0, "events cleared");
    wrt(bcc_pkg::ADDR_INT_MASK, 32'h0);
  endtask
  task t_disable;
    wrt(bcc_pkg::ADDR_CTRL, 32'h0);
    level <= 16'h2201; ticks;
    `CHK("brake off", 1'b0, brake)
    `CHK("hold off", 1'b0, hold)
    rdc(bcc_pkg::ADDR_STATUS, 32'h0, "status off");
    rdc(bcc_pkg::ADDR_BUS_V, 32'h2201, "bus off");
    wrt(bcc_pkg::ADDR_CTRL, 32'h1); ticks;
    `CHK("brake again", 1'b1, brake)
  endtask
  task t_trip;
    level <= 16'h2200;
    wrt(bcc_pkg::ADDR_OHMS, 32'h1);
    wrt(bcc_pkg::ADDR_FACTOR, 32'h1);
    wrt(bcc_pkg::ADDR_CTRL, 32'h3);
    ticks; ticks;
    `CHK("trip", 1'b1, trip)
    rdv(bcc_pkg::ADDR_LOAD);
    `CHK("load", 1'b1, d != 32'h0)
    rdv(bcc_pkg::ADDR_SW_ENERGY);
    `CHK("energy", 1'b1, d != 32'h0)
    rdc(bcc_pkg::ADDR_STATUS, 32'h7, "status trip");
    rdc(bcc_pkg::ADDR_INT_STAT, 32'h7, "trip event");
    wrt(bcc_pkg::ADDR_CTRL, 32'h1);
    repeat (2) @(posedge clk); #1;
    `CHK("trip off", 1'b0, trip)
    rdc(bcc_pkg::ADDR_STATUS, 32'h3, "status trip off");
  endtask
  task finish_test;
    $display("compares %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_defaults; t_clamp; t_brake; t_irq; t_disable;
    level <= 16'h2000; ticks;
    t_trip;
    finish_test;
  end
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    finish_test;
  end
endmodule
bind bcc_top bcc_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .bus_voltage_i(bus_voltage_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .brake_switch_o(brake_switch_o), .ramp_hold_o(ramp_hold_o),
  .overload_trip_o(overload_trip_o), .irq_o(irq_o));
`default_nettype wire
